/* alarm_pkg.sv */
// Constants, alarm codes and types for the alarm manager.
// Assumes a 200 MHz system clock and an APB register port.
package alarm_pkg;
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned MS_CYC = 1000000 / CLK_PERIOD_NS;
   localparam int unsigned BLINK_ON_MS = 200;
   localparam int unsigned BLINK_OFF_MS = 200;
   localparam int unsigned BLINK_GAP_MS = 1000;
   localparam int unsigned BLINK_ON_CYC = BLINK_ON_MS * MS_CYC;
   localparam int unsigned BLINK_OFF_CYC = BLINK_OFF_MS * MS_CYC;
   localparam int unsigned BLINK_GAP_CYC = BLINK_GAP_MS * MS_CYC;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DRV_LIM = 8'h04;
   localparam logic [7:0] OFS_MOT_LIM = 8'h08;
   localparam logic [7:0] OFS_OL_LIM = 8'h0C;
   localparam logic [7:0] OFS_VEL_LIM = 8'h10;
   localparam logic [7:0] OFS_CMD = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // Field positions
   localparam int CTRL_OUT_EN = 0;
   localparam int CTRL_OUT_POL = 1;
   localparam int CTRL_ACT_LO = 4;
   localparam int CMD_CLEAR = 0;
   localparam int CMD_RAISE = 1;
   localparam int CMD_RESET = 2;
   // Reset values
   localparam logic [15:0] RST_DRV_LIM = 16'h0055;
   localparam logic [15:0] RST_MOT_LIM = 16'h0050;
   localparam logic [15:0] RST_OL_LIM = 16'h01F4;
   localparam logic [15:0] RST_VEL_LIM = 16'h1000;
   // Alarm codes and blink counts
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_STACK = 8'h90;
   localparam logic [7:0] CODE_SEQ_REF = 8'h94;
   localparam logic [7:0] CODE_CALC_OVF = 8'h98;
   localparam logic [7:0] CODE_PRM_RANGE = 8'h99;
   localparam logic [7:0] CODE_ZERO_DIV = 8'h9A;
   localparam logic [7:0] CODE_POS_BUSY = 8'h9D;
   localparam logic [7:0] CODE_VAR_REF = 8'h9E;
   localparam logic [7:0] CODE_PRM_WRITE = 8'h9F;
   localparam logic [7:0] CODE_MOTION = 8'hA0;
   localparam logic [7:0] CODE_USER = 8'hE0;
   localparam logic [7:0] CODE_DRV_HOT = 8'h21;
   localparam logic [7:0] CODE_MOT_HOT = 8'h26;
   localparam logic [7:0] CODE_OVERLOAD = 8'h30;
   localparam logic [7:0] CODE_VELOCITY_LIMIT = 8'h31;
   localparam logic [3:0] BLINK_SEQ = 4'h1;
   localparam logic [3:0] BLINK_HOT = 4'h2;
   // Clearing classes
   localparam logic [1:0] CLS_CMD = 2'h0;
   localparam logic [1:0] CLS_GONE = 2'h1;
   localparam logic [1:0] CLS_RESET = 2'h2;
   localparam logic [1:0] CLS_NEVER = 2'h3;
   // Reactions
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_STOP = 2'h1;
   localparam logic [1:0] ACT_CUROFF = 2'h2;

   typedef struct packed {
      logic stack_ovf;
      logic seq_ref;
      logic calc_ovf;
      logic param_range;
      logic zero_div;
      logic var_ref;
      logic param_write;
      logic motion_clash;
   } seq_fault_t;

   typedef struct packed {
      logic [15:0] drive_temp;
      logic [15:0] motor_temp;
      logic [15:0] velocity;
      logic torque_at_max;
   } monitor_t;

   typedef enum logic [3:0] {
      BL_IDLE = 4'b0001,
      BL_ON = 4'b0010,
      BL_OFF = 4'b0100,
      BL_GAP = 4'b1000
   } blink_st_t;

   typedef struct packed {
      logic active;
      logic [7:0] code;
      logic [3:0] blinks;
      logic [1:0] cls;
      logic [1:0] act;
      logic out_en;
      logic out_pol;
      logic [1:0] act_cfg;
      logic [15:0] drv_lim;
      logic [15:0] mot_lim;
      logic [15:0] ol_lim;
      logic [15:0] vel_lim;
      logic [15:0] ol_cnt;
      logic [31:0] ms_cnt;
      blink_st_t bst;
      logic [31:0] btmr;
      logic [3:0] bcnt;
      logic led;
      logic alarm_query_cmd;
      logic stop;
      logic cur_off;
      logic grant;
      logic pready;
      logic slverr;
      logic [31:0] prdata;
   } state_t;
endpackage : alarm_pkg

/* alarm_protection_manager.sv */
// Alarm manager: latches fault codes, blinks the indicator, drives the
// alarm output and stops motion or cuts current. APB register port.
// Assumes fault inputs are synchronous to SYS_CLK_IN.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - Fault blinks indicator, drives configured alarm output
// RULE2 - Alarms stop motion or cut motor current; overload and overspeed alarms set to no reaction do neither
// RULE3 - Four clearing classes: command, condition gone, reset, never
// RULE4 - Stack exhausted gives 0x90, one blink, clearable
// RULE5 - Missing sequence call gives 0x94
// RULE6 - Arithmetic overflow gives 0x98
// RULE7 - Parameter out of range gives 0x99
// RULE8 - Divide by zero gives 0x9A
// RULE9 - Position write while moving refused, 0x9D
// RULE10 - Missing user variable gives 0x9E
// RULE11 - Forbidden parameter change gives 0x9F
// RULE12 - Clashing motion start gives 0xA0
// RULE13 - User raise command gives clearable 0xE0
// RULE14 - Driver overheat: 0x21, two blinks, current off
// RULE15 - Motor overheat: 0x26, current off
// RULE16 - Overload time exceeded: 0x30, configured reaction
// RULE17 - Overspeed: 0x31, configured reaction, clear when gone
// RULE18 - Alarm code readable on query
// RULE19 - Reset command or power cycle clears alarms
// RULE20 - No alarm: code zero, dark, normal operation
// RULE21 - Clear ignored while condition persists or unclearable
module alarm_protection_manager
   import alarm_pkg::*;
#(
   parameter int unsigned MS_TICK_CYC = MS_CYC,
   parameter int unsigned BLINK_ON = BLINK_ON_CYC,
   parameter int unsigned BLINK_OFF = BLINK_OFF_CYC,
   parameter int unsigned BLINK_GAP = BLINK_GAP_CYC
) (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Fault sources
   input wire seq_fault_t SEQ_FAULT_IN,
   input wire monitor_t MON_IN,
   input wire logic POS_WR_REQ_IN,
   input wire logic MOTION_BUSY_IN,
   // Alarm reactions
   output logic ALARM_LED_OUT,
   output logic ALARM_OUT,
   output logic MOTION_STOP_OUT,
   output logic CURRENT_OFF_OUT,
   output logic POS_WR_GRANT_OUT,
   output logic [7:0] ALARM_CODE_OUT
);

   if (MS_TICK_CYC < 1 || BLINK_ON < 1 || BLINK_OFF < 1 ||
       BLINK_GAP < 1) begin : g_param_check
      $error("Timing parameters must be at least one cycle");
   end

   state_t s_r;
   state_t s_nxt;
   logic drv_hot, mot_hot, ol_over, vel_over, hw_cand, cand, cond_now;
   logic acc, wr_done, mapped, cmd_clr, cmd_raise, cmd_rst, tick, clr_ok;
   logic [9:0] seq_ev;
   logic [7:0] c_code;
   logic [3:0] c_bl;
   logic [1:0] c_cls, c_act;
   logic [31:0] rd;

   always_comb begin
      s_nxt = s_r;
      drv_hot = MON_IN.drive_temp > s_r.drv_lim;
      mot_hot = MON_IN.motor_temp > s_r.mot_lim;
      ol_over = s_r.ol_cnt > s_r.ol_lim;
      vel_over = MON_IN.velocity > s_r.vel_lim;
      hw_cand = drv_hot | mot_hot | ol_over | vel_over;
      // Overload timer in ms ticks while torque is at maximum
      tick = s_r.ms_cnt == 32'(MS_TICK_CYC - 1);
      s_nxt.ms_cnt = tick ? 32'h0000_0000 : s_r.ms_cnt + 32'h0000_0001;
      if (!MON_IN.torque_at_max) begin
         s_nxt.ol_cnt = 16'h0000;
      end else if (tick && !ol_over) begin
         s_nxt.ol_cnt = s_r.ol_cnt + 16'h0001; // see RULE16
      end
      // APB: one wait state, write lands at the completing edge
      acc = PSEL_IN & PENABLE_IN;
      wr_done = acc & PWRITE_IN & s_r.pready;
      mapped = PADDR_IN <= OFS_STATUS && PADDR_IN[1:0] == 2'b00;
      rd = 32'h0000_0000;
      case (PADDR_IN)
         OFS_CTRL: rd = {26'h000_0000, s_r.act_cfg, 2'b00, s_r.out_pol,
                         s_r.out_en};
         OFS_DRV_LIM: rd = {16'h0000, s_r.drv_lim};
         OFS_MOT_LIM: rd = {16'h0000, s_r.mot_lim};
         OFS_OL_LIM: rd = {16'h0000, s_r.ol_lim};
         OFS_VEL_LIM: rd = {16'h0000, s_r.vel_lim};
         OFS_STATUS: rd = {16'h0000, drv_hot, mot_hot, ol_over, vel_over,
                           s_r.cls, 1'b0, s_r.active, s_r.code}; // see RULE18
         default: rd = 32'h0000_0000;
      endcase
      s_nxt.pready = acc & ~s_r.pready;
      s_nxt.slverr = acc & ~s_r.pready & ~mapped;
      if (acc && !s_r.pready) begin
         s_nxt.prdata = PWRITE_IN ? 32'h0000_0000 : rd;
      end
      if (wr_done) begin
         case (PADDR_IN)
            OFS_CTRL: begin
               s_nxt.out_en = PWDATA_IN[CTRL_OUT_EN];
               s_nxt.out_pol = PWDATA_IN[CTRL_OUT_POL];
               s_nxt.act_cfg = PWDATA_IN[CTRL_ACT_LO +: 2];
            end
            OFS_DRV_LIM: s_nxt.drv_lim = PWDATA_IN[15:0];
            OFS_MOT_LIM: s_nxt.mot_lim = PWDATA_IN[15:0];
            OFS_OL_LIM: s_nxt.ol_lim = PWDATA_IN[15:0];
            OFS_VEL_LIM: s_nxt.vel_lim = PWDATA_IN[15:0];
            default: s_nxt.act_cfg = s_nxt.act_cfg;
         endcase
      end
      cmd_clr = wr_done & PADDR_IN == OFS_CMD & PWDATA_IN[CMD_CLEAR];
      cmd_raise = wr_done & PADDR_IN == OFS_CMD & PWDATA_IN[CMD_RAISE];
      cmd_rst = wr_done & PADDR_IN == OFS_CMD & PWDATA_IN[CMD_RESET];
      seq_ev = {cmd_raise, POS_WR_REQ_IN & MOTION_BUSY_IN, SEQ_FAULT_IN};
      // Fault selection, monitors first
      cand = 1'b1;
      c_bl = BLINK_HOT;
      c_cls = CLS_GONE;
      c_act = s_r.act_cfg;
      c_code = CODE_NONE;
      if (drv_hot) begin
         c_code = CODE_DRV_HOT; // see RULE14
         c_act = ACT_CUROFF;
      end else if (mot_hot) begin
         c_code = CODE_MOT_HOT; // see RULE15
         c_act = ACT_CUROFF;
      end else if (ol_over) begin
         c_code = CODE_OVERLOAD; // see RULE16
      end else if (vel_over) begin
         c_code = CODE_VELOCITY_LIMIT; // see RULE17
      end else begin
         c_bl = BLINK_SEQ;
         c_cls = CLS_CMD; // see RULE3
         c_act = ACT_STOP; // see RULE2
         if (seq_ev[7]) c_code = CODE_STACK; // see RULE4
         else if (seq_ev[6]) c_code = CODE_SEQ_REF; // see RULE5
         else if (seq_ev[5]) c_code = CODE_CALC_OVF; // see RULE6
         else if (seq_ev[4]) c_code = CODE_PRM_RANGE; // see RULE7
         else if (seq_ev[3]) c_code = CODE_ZERO_DIV; // see RULE8
         else if (seq_ev[2]) c_code = CODE_VAR_REF; // see RULE10
         else if (seq_ev[1]) c_code = CODE_PRM_WRITE; // see RULE11
         else if (seq_ev[0]) c_code = CODE_MOTION; // see RULE12
         else if (seq_ev[8]) c_code = CODE_POS_BUSY; // see RULE9
         else if (seq_ev[9]) c_code = CODE_USER; // see RULE13
         else cand = 1'b0;
      end
      // Clearing by class; condition must be gone for monitor alarms
      case (s_r.code)
         CODE_DRV_HOT: cond_now = drv_hot;
         CODE_MOT_HOT: cond_now = mot_hot;
         CODE_OVERLOAD: cond_now = ol_over;
         CODE_VELOCITY_LIMIT: cond_now = vel_over;
         default: cond_now = 1'b0;
      endcase
      clr_ok = s_r.active & ((cmd_clr & (s_r.cls == CLS_CMD
               | (s_r.cls == CLS_GONE & ~cond_now))) // see RULE21
               | (cmd_rst & s_r.cls != CLS_NEVER)); // see RULE19
      if (clr_ok) begin
         s_nxt.active = 1'b0;
         s_nxt.code = CODE_NONE; // see RULE20
      end
      // A new fault wins over a clear in the same cycle
      if (!s_nxt.active && cand) begin
         s_nxt.active = 1'b1;
         s_nxt.code = c_code;
         s_nxt.blinks = c_bl;
         s_nxt.cls = c_cls;
         s_nxt.act = c_act;
      end
      // Indicator blink sequence: n pulses then a long gap
      s_nxt.btmr = s_r.btmr + 32'h0000_0001;
      case (s_r.bst)
         BL_IDLE: begin
            s_nxt.bst = BL_ON;
            s_nxt.btmr = 32'h0000_0000;
            s_nxt.bcnt = 4'h1;
         end
         BL_ON: begin
            if (s_r.btmr >= 32'(BLINK_ON - 1)) begin
               s_nxt.bst = BL_OFF;
               s_nxt.btmr = 32'h0000_0000;
            end
         end
         BL_OFF: begin
            if (s_r.btmr >= 32'(BLINK_OFF - 1)) begin
               s_nxt.btmr = 32'h0000_0000;
               if (s_r.bcnt >= s_r.blinks) begin
                  s_nxt.bst = BL_GAP;
               end else begin
                  s_nxt.bst = BL_ON;
                  s_nxt.bcnt = s_r.bcnt + 4'h1;
               end
            end
         end
         BL_GAP: begin
            if (s_r.btmr >= 32'(BLINK_GAP - 1)) begin
               s_nxt.bst = BL_ON;
               s_nxt.btmr = 32'h0000_0000;
               s_nxt.bcnt = 4'h1;
            end
         end
         default: s_nxt.bst = BL_IDLE;
      endcase
      if (!s_r.active || s_nxt.code != s_r.code) begin
         s_nxt.bst = BL_IDLE;
         s_nxt.btmr = 32'h0000_0000;
      end
      s_nxt.led = s_nxt.active & s_nxt.bst == BL_ON; // see RULE1
      s_nxt.alarm_query_cmd = s_nxt.out_en & (s_nxt.active ? s_nxt.out_pol
                                               : ~s_nxt.out_pol); // see RULE1
      s_nxt.stop = s_nxt.active & s_nxt.act != ACT_NONE; // see RULE2
      s_nxt.cur_off = s_nxt.active & s_nxt.act == ACT_CUROFF; // see RULE2
      s_nxt.grant = POS_WR_REQ_IN & ~MOTION_BUSY_IN; // see RULE9
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         s_r <= '0;
         s_r.code <= CODE_NONE;
         s_r.cls <= CLS_CMD;
         s_r.act <= ACT_NONE;
         s_r.act_cfg <= ACT_STOP;
         s_r.drv_lim <= RST_DRV_LIM;
         s_r.mot_lim <= RST_MOT_LIM;
         s_r.ol_lim <= RST_OL_LIM;
         s_r.vel_lim <= RST_VEL_LIM;
         s_r.bst <= BL_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign PRDATA_OUT = s_r.prdata;
   assign PREADY_OUT = s_r.pready;
   assign PSLVERR_OUT = s_r.slverr;
   assign ALARM_LED_OUT = s_r.led;
   assign ALARM_OUT = s_r.alarm_query_cmd;
   assign MOTION_STOP_OUT = s_r.stop;
   assign CURRENT_OFF_OUT = s_r.cur_off;
   assign POS_WR_GRANT_OUT = s_r.grant;
   assign ALARM_CODE_OUT = s_r.code;

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (SRST_IN);

   property p_alarm_out;
      $rose(s_r.active) && s_r.out_en |-> ALARM_OUT == s_r.out_pol;
   endproperty
   a_alarm_out: assert property (p_alarm_out) // see RULE1
      else $error("Alarm output not at active level");

   property p_stop;
      s_r.active && s_r.act != ACT_NONE |-> MOTION_STOP_OUT;
   endproperty
   a_stop: assert property (p_stop) // see RULE2
      else $error("Motion not stopped during alarm");

   property p_stack;
      SEQ_FAULT_IN.stack_ovf && !s_r.active && !hw_cand |=>
         ALARM_CODE_OUT == 8'h90 && s_r.blinks == 4'h1 && MOTION_STOP_OUT;
   endproperty
   a_stack: assert property (p_stack) // see RULE4
      else $error("Stack alarm not recorded");

   property p_pos;
      POS_WR_REQ_IN && MOTION_BUSY_IN |=> !POS_WR_GRANT_OUT && s_r.active;
   endproperty
   a_pos: assert property (p_pos) // see RULE9
      else $error("Position write while moving not refused");

   property p_raise;
      cmd_raise && !s_r.active && !hw_cand && seq_ev[8:0] == 9'h000 |=>
         ALARM_CODE_OUT == 8'hE0;
   endproperty
   a_raise: assert property (p_raise) // see RULE13
      else $error("User alarm not raised");

   property p_drv;
      drv_hot && !s_r.active |=> ALARM_CODE_OUT == 8'h21 && CURRENT_OFF_OUT
         ##[1:2] ALARM_LED_OUT;
   endproperty
   a_drv: assert property (p_drv) // see RULE14
      else $error("Driver overheat reaction wrong");

   property p_query;
      acc && !s_r.pready && !PWRITE_IN && PADDR_IN == OFS_STATUS |=>
         PREADY_OUT && PRDATA_OUT[7:0] == $past(ALARM_CODE_OUT);
   endproperty
   a_query: assert property (p_query) // see RULE18
      else $error("Status read did not return alarm code");

   property p_reset_cmd;
      cmd_rst && s_r.active && s_r.cls != CLS_NEVER && !cand |=> !s_r.active;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) // see RULE19
      else $error("Reset command did not clear alarm");

   property p_idle;
      !s_r.active |-> ALARM_CODE_OUT == 8'h00 && !ALARM_LED_OUT
         && !MOTION_STOP_OUT && !CURRENT_OFF_OUT;
   endproperty
   a_idle: assert property (p_idle) // see RULE20
      else $error("Alarm indication without active alarm");

   property p_clear_hold;
      s_r.active && s_r.cls == CLS_GONE && cond_now && cmd_clr && !cmd_rst
         |=> s_r.active && ALARM_CODE_OUT == $past(ALARM_CODE_OUT);
   endproperty
   a_clear_hold: assert property (p_clear_hold) // see RULE21
      else $error("Clear removed alarm with condition present");

endmodule : alarm_protection_manager
`default_nettype wire

/* alarm_host_model.sv */
// Host and fault-source model that drives every input of the alarm manager except clock and reset.
// Assumes the bench supplies the system clock and calls the tasks below.
`timescale 1ns/1ps
`default_nettype none
module alarm_host_model
   import alarm_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // APB master
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [7:0] paddr_out,
   output logic [31:0] pwdata_out,
   input wire logic [31:0] prdata_in,
   input wire logic pready_in,
   input wire logic pslverr_in,
   // Fault sources
   output seq_fault_t seq_out,
   output monitor_t mon_out,
   output logic pos_req_out,
   output logic busy_out
);
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h00;
      pwdata_out = 32'h0000_0000;
      seq_out = '0;
      mon_out = '0;
      pos_req_out = 1'b0;
      busy_out = 1'b0;
   end
   // One transfer, held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] addr,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge clk_in);
      psel_out <= 1'b1;
      pwrite_out <= wr;
      paddr_out <= addr;
      pwdata_out <= wd;
      @(posedge clk_in);
      penable_out <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready_in !== 1'b1);
      rd = prdata_in;
      err = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // Released lines carry no stale value
      paddr_out <= ~addr;
      pwdata_out <= ~wd;
   endtask : xfer
   // One-cycle event pulse
   task automatic pulse(input seq_fault_t f);
      @(posedge clk_in);
      seq_out <= f;
      @(posedge clk_in);
      seq_out <= '0;
   endtask : pulse
   task automatic levels(input monitor_t m, input logic req, input logic bsy);
      @(posedge clk_in);
      mon_out <= m;
      pos_req_out <= req;
      busy_out <= bsy;
   endtask : levels
endmodule : alarm_host_model
`default_nettype wire

/* alarm_protection_manager_tb.sv */
// Self-checking bench for the alarm manager against a reference model.
// Assumes alarm_host_model drives the inputs; blink and tick timings are shortened.
`timescale 1ns/1ps
`default_nettype none
module alarm_protection_manager_tb
   import alarm_pkg::*;
;
   localparam int TICK = 4;
   localparam int BON = 3;
   localparam int BOFF = 3;
   logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, code;
   logic [31:0] pwdata, prdata, rd;
   seq_fault_t seq;
   monitor_t mon, mv;
   logic pos_req, busy, led, alarm_query_cmd, stop, cur, grant;
   int err_total = 0;
   int check_count = 0;
   int m_code, m_stop, m_cur, m_en, m_pol;
   int seq_codes[$] = '{'h90, 'h94, 'h98, 'h99, 'h9A, 'h9E, 'h9F, 'hA0};

   alarm_protection_manager #(.MS_TICK_CYC(TICK), .BLINK_ON(BON),
      .BLINK_OFF(BOFF), .BLINK_GAP(8)) alarm_protection_manager_inst (
      .SYS_CLK_IN(sys_clk), .SRST_IN(srst), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .SEQ_FAULT_IN(seq), .MON_IN(mon),
      .POS_WR_REQ_IN(pos_req), .MOTION_BUSY_IN(busy), .ALARM_LED_OUT(led),
      .ALARM_OUT(alarm_query_cmd), .MOTION_STOP_OUT(stop), .CURRENT_OFF_OUT(cur),
      .POS_WR_GRANT_OUT(grant), .ALARM_CODE_OUT(code));
   alarm_host_model alarm_host_model_inst (.clk_in(sys_clk),
      .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
      .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
      .pready_in(pready), .pslverr_in(pslverr), .seq_out(seq),
      .mon_out(mon), .pos_req_out(pos_req), .busy_out(busy));

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic set_m(input int c, input int s, input int u);
      m_code = c;
      m_stop = s;
      m_cur = u;
   endtask : set_m
   // Reaction outputs against the model; stop below zero is not checked
   task automatic outs;
      chk(32'(code), 32'(m_code), "code");
      chk(32'(cur), 32'(m_cur), "current off");
      if (m_stop >= 0) chk(32'(stop), 32'(m_stop), "stop");
      chk(32'(alarm_query_cmd), (m_en != 0) ? 32'((m_code != 0) ? m_pol : 1 - m_pol)
         : 32'h0, "alarm out");
   endtask : outs
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      alarm_host_model_inst.xfer(1'b1, a, d, rd, er);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
      input logic eexp);
      alarm_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rd, er);
      chk(rd, exp, "read data");
      chk(32'(er), 32'(eexp), "slave error");
   endtask : rdchk
   task automatic ctrl(input int en, input int pol, input int act);
      m_en = en;
      m_pol = pol;
      wr(OFS_CTRL, 32'(en | (pol << 1) | (act << 4)));
   endtask : ctrl
   task automatic fire(input int i);
      alarm_host_model_inst.pulse(seq_fault_t'(8'h80 >> i));
      step(1);
      set_m(seq_codes[i], 1, 0);
   endtask : fire
   task automatic cmd(input int bits, input int clears);
      wr(OFS_CMD, 32'(bits));
      step(1);
      if (clears != 0) set_m(0, 0, 0);
   endtask : cmd
   task automatic lv(input logic req, input logic bsy);
      alarm_host_model_inst.levels(mv, req, bsy);
      step(2);
   endtask : lv
   // High two edges after the event, so already lit on entry; n pulses
   task automatic blinks(input int n);
      int k, rises, prev;
      k = 0;
      while (led !== 1'b1 && k < 4) begin
         step(1);
         k++;
      end
      chk(32'(k), 32'h0, "led delay");
      rises = 1;
      prev = 1;
      repeat (n * (BON + BOFF) - 1) begin
         step(1);
         if (led === 1'b1 && prev == 0) rises++;
         prev = (led === 1'b1);
      end
      chk(32'(rises), 32'(n), "blink count");
   endtask : blinks

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      int r, j, k;
      mv = '0;
      set_m(0, 0, 0);
      m_en = 0;
      m_pol = 0;
      r = $urandom(91955);
      srst = 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      step(1);
      outs();
      rdchk(OFS_CTRL, 32'h0000_0010, 1'b0);
      rdchk(OFS_DRV_LIM, 32'h0000_0055, 1'b0);
      rdchk(OFS_MOT_LIM, 32'h0000_0050, 1'b0);
      rdchk(OFS_OL_LIM, 32'h0000_01F4, 1'b0);
      rdchk(OFS_VEL_LIM, 32'h0000_1000, 1'b0);
      rdchk(OFS_STATUS, 32'h0000_0000, 1'b0);
      wr(8'h1C, 32'hFFFF_FFFF);
      chk(32'(er), 32'h1, "unmapped write");
      rdchk(8'h1C, 32'h0000_0000, 1'b1);
      fire(0);
      outs();
      blinks(1);
      alarm_host_model_inst.pulse(seq_fault_t'(8'h08));
      step(1);
      outs();
      rdchk(OFS_STATUS, 32'h0000_0190, 1'b0);
      cmd(1, 1);
      outs();
      for (j = 0; j < 8; j++) begin
         ctrl(1, $urandom % 2, 1);
         fire(j);
         outs();
         cmd(1, 1);
         outs();
      end
      lv(1'b1, 1'b0);
      chk(32'(grant), 32'h1, "grant");
      outs();
      lv(1'b1, 1'b1);
      set_m('h9D, 1, 0);
      chk(32'(grant), 32'h0, "refused grant");
      outs();
      lv(1'b0, 1'b0);
      cmd(1, 1);
      cmd(2, 0);
      set_m('hE0, 1, 0);
      outs();
      cmd(1, 1);
      outs();
      for (j = 0; j < 2; j++) begin
         mv.drive_temp = (j == 0) ? 16'h0056 : 16'h0055;
         mv.motor_temp = (j == 1) ? 16'h0051 : 16'h0050;
         lv(1'b0, 1'b0);
         set_m((j == 0) ? 'h21 : 'h26, -1, 1);
         outs();
         if (j == 0) blinks(2);
         rdchk(OFS_STATUS, (j == 0) ? 32'h0000_8521 : 32'h0000_4526, 1'b0);
         cmd(1, 0);
         outs();
         mv.drive_temp = 16'($urandom % 'h56);
         mv.motor_temp = 16'($urandom % 'h51);
         lv(1'b0, 1'b0);
         cmd(1, 1);
         outs();
      end
      for (j = 0; j < 3; j++) begin
         ctrl(1, 1, j);
         mv.velocity = 16'h1001;
         lv(1'b0, 1'b0);
         set_m('h31, (j == 2) ? -1 : int'(j == 1), int'(j == 2));
         outs();
         cmd(1, 0);
         outs();
         mv.velocity = 16'h1000;
         lv(1'b0, 1'b0);
         cmd(1, 1);
         outs();
      end
      wr(OFS_OL_LIM, 32'h0000_0002);
      mv.torque_at_max = 1'b1;
      alarm_host_model_inst.levels(mv, 1'b0, 1'b0);
      k = 0;
      while (code !== 8'h30 && k < 100) begin
         step(1);
         k++;
      end
      chk(32'(k >= 2 * TICK && k <= 6 * TICK), 32'h1, "overload time");
      set_m('h30, -1, 1);
      outs();
      rdchk(OFS_STATUS, 32'h0000_2530, 1'b0);
      mv.torque_at_max = 1'b0;
      lv(1'b0, 1'b0);
      cmd(1, 1);
      outs();
      fire(2);
      cmd(4, 1);
      outs();
      fire(3);
      @(posedge sys_clk);
      srst <= 1'b1;
      @(posedge sys_clk);
      srst <= 1'b0;
      step(1);
      set_m(0, 0, 0);
      m_en = 0;
      outs();
      rdchk(OFS_CTRL, 32'h0000_0010, 1'b0);
      tally_and_finish();
   end
endmodule : alarm_protection_manager_tb
`default_nettype wire
